// >>> core/pssc_ctrl.sv
// Derivative term, feedback filter, start-stabilize sequencer and alarms
`timescale 1ns/1ps
// How it works
// - Derivative time accepted 0.00..600.00 s, clamped to maximum.
// - Derivative time zero gives no derivative contribution.
// - Derivative term is derivative time times change of deviation per cycle.
// - Feedback low-pass filtered, time constant 0.0..900.0 s.
// - Stabilize uses stabilize frequency as reference, bounded by max time.
// - Filtered feedback reaching stabilize level ends stabilize, hands to PID.
// - Time expiry or cancel terminate stabilize with stop.
// - Cancel terminal function 72 disables start-stabilize.
// - Stabilize runs only when PID is the active mode.
// - Stabilize ramp uses stabilize acceleration time.
// - Stabilize frequency below low limiter uses low limiter.
// - Stabilize entered only from stopped condition.
// - Stabilize enabled only when stabilize frequency exceeds zero.
// - Stabilize-active indicator asserted while stabilize active.
// - Absolute and deviation alarms; outputs by function codes 42, 50.
// - Absolute alarm on when value below lower or above upper limit.
// - Hold types stay off until value leaves then re-enters alarm range.
// - Latch types stay on until a reset command clears them.
module pssc_ctrl #(
   parameter int unsigned W = pssc_pkg::DATA_W
) (
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     run_cmd_i,
   input  wire logic                     pid_mode_i,
   input  wire logic                     motor_stopped_i,
   input  wire logic                     stabilize_cancel_input_i,
   input  wire logic                     alarm_reset_i,
   input  wire logic [7:0]               di_function_i,
   input  wire logic [7:0]               do_function_i,
   input  wire logic [15:0]              derivative_time_setting_i,
   input  wire logic [15:0]              feedback_filter_time_i,
   input  wire pssc_pkg::pssc_stab_cfg_t  stab_cfg_i,
   input  wire pssc_pkg::pssc_alarm_cfg_t alarm_cfg_i,
   input  wire logic [W-1:0]             process_setpoint_i,
   input  wire logic [W-1:0]             feedback_i,
   output logic [W-1:0]                  measured_process_value_o,
   output logic [31:0]                   derivative_term_o,
   output logic [15:0]                   freq_ref_o,
   output logic [15:0]                   accel_time_o,
   output logic                          use_pid_o,
   output logic                          stop_o,
   output logic                          stabilize_active_indicator_o,
   output logic                          pid_alarm_output_o,
   output logic                          feedback_alarm_output_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_STAB, ST_PID, ST_STOP}
      pssc_state_t;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // ==========================================
   // Input synchronisers
   logic cancel_m_reg;
   logic cancel_s_reg;
   always_ff @(posedge core_clk_i)
   begin
      cancel_m_reg <= rst_i ? 1'b0 : stabilize_cancel_input_i;
      cancel_s_reg <= rst_i ? 1'b0 : cancel_m_reg;
   end
   wire cancel = cancel_s_reg
                 && (di_function_i == pssc_pkg::FUNC_CANCEL);

   // ==========================================
   // Control cycle divider
   logic [31:0] div_reg;
   logic [31:0] div_next;
   logic        tick;
   always_comb
   begin
      tick     = (div_reg == 32'(pssc_pkg::CTRL_CYCLES - 1));
      div_next = tick ? 32'h0 : div_reg + 32'h1;
   end
   always_ff @(posedge core_clk_i)
      div_reg <= rst_i ? 32'h0 : div_next;

   // ==========================================
   // Feedback filter
   logic [W-1:0] pv;
   logic [15:0]  tau;
   assign tau = (feedback_filter_time_i > pssc_pkg::FILT_MAX) ?
                pssc_pkg::FILT_MAX : feedback_filter_time_i;
   pssc_lpf #(.W(W)) u_lpf (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .tick_i     (tick),
      .tau_i      (tau),
      .x_i        (feedback_i),
      .y_o        (pv)
   );

   // ==========================================
   // Derivative term
   logic signed [W:0]  dev_reg;
   logic signed [W:0]  dev_next;
   logic [31:0]        dterm_reg;
   logic [31:0]        dterm_next;
   logic [15:0]        td;
   always_comb
   begin
      td = (derivative_time_setting_i > pssc_pkg::DERIV_MAX) ?
           pssc_pkg::DERIV_MAX : derivative_time_setting_i;
      dev_next   = dev_reg;
      dterm_next = dterm_reg;
      if (tick)
      begin
         dev_next   = $signed({1'b0, process_setpoint_i})
                      - $signed({1'b0, pv});
         // Widen before the product so long times do not wrap
         dterm_next = $signed(32'(dev_next - dev_reg))
                      * $signed(32'({1'b0, td}));
      end
      // Zero time clears the term at once, not at the next tick
      if (td == 16'h0000)
         dterm_next = 32'h0;
   end
   always_ff @(posedge core_clk_i)
   begin
      dev_reg   <= rst_i ? '0 : dev_next;
      dterm_reg <= rst_i ? 32'h0 : dterm_next;
   end

   // ==========================================
   // Start-stabilize sequencer
   pssc_state_t st_reg;
   pssc_state_t st_next;
   logic [31:0] tm_reg;
   logic [31:0] tm_next;
   logic [15:0] sfreq;
   logic [31:0] tlim;
   always_comb
   begin
      sfreq = (stab_cfg_i.stabilize_frequency < stab_cfg_i.low_frequency_limit)
              ? stab_cfg_i.low_frequency_limit
              : stab_cfg_i.stabilize_frequency;
      tlim    = {16'h0000, stab_cfg_i.stabilize_max_time}
                * 32'(pssc_pkg::TENTH_TICKS);
      st_next = st_reg;
      tm_next = tm_reg;
      case (st_reg)
         ST_IDLE:
            if (run_cmd_i && pid_mode_i)
            begin
               if (motor_stopped_i && !cancel
                   && stab_cfg_i.stabilize_frequency
                      > pssc_pkg::FREQ_ZERO)
               begin
                  st_next = ST_STAB;
                  tm_next = 32'h0;
               end
               else
                  st_next = ST_PID;
            end
         ST_STAB:
         begin
            if (tick)
               tm_next = tm_reg + 32'h1;
            if (!run_cmd_i || !pid_mode_i)
               st_next = ST_IDLE;
            else if (pv >= W'(stab_cfg_i.stabilize_level))
               st_next = ST_PID;
            else if (cancel || tm_reg >= tlim)
               st_next = ST_STOP;
         end
         ST_PID:
            if (!run_cmd_i || !pid_mode_i)
               st_next = ST_IDLE;
         ST_STOP:
            if (!run_cmd_i)
               st_next = ST_IDLE;
         default:
            st_next = ST_IDLE;
      endcase
   end
   always_ff @(posedge core_clk_i)
   begin
      st_reg <= rst_i ? ST_IDLE : st_next;
      tm_reg <= rst_i ? 32'h0 : tm_next;
   end

   // ==========================================
   // Alarms
   logic          raw;
   logic          armed_reg, armed_next;
   logic          was_out_reg, was_out_next;
   logic          alm_reg, alm_next;
   logic [W:0]    lo, hi;
   logic          hold, latch;
   logic [3:0]    typ;
   always_comb
   begin
      typ   = alarm_cfg_i.alarm_type_select;
      hold  = (typ == 4'h2) || (typ == 4'h4) || (typ == 4'h6) || (typ == 4'h8);
      latch = (typ == 4'h3) || (typ == 4'h4) || (typ == 4'h7) || (typ == 4'h8);
      if (typ >= pssc_pkg::ALM_DEV_FIRST)
      begin
         lo = {1'b0, process_setpoint_i}
              - {1'b0, W'(alarm_cfg_i.lower_alarm_limit)};
         hi = {1'b0, process_setpoint_i}
              + {1'b0, W'(alarm_cfg_i.upper_alarm_limit)};
         if (lo[W])
            lo = '0;
      end
      else
      begin
         lo = {1'b0, W'(alarm_cfg_i.lower_alarm_limit)};
         hi = {1'b0, W'(alarm_cfg_i.upper_alarm_limit)};
      end
      raw = (typ >= pssc_pkg::ALM_ABS) && (typ <= pssc_pkg::ALM_LAST)
            && (({1'b0, pv} < lo) || (hi < {1'b0, pv}));
      was_out_next = was_out_reg || !raw;
      armed_next   = armed_reg || !hold || (was_out_reg && raw);
      alm_next     = raw && armed_next;
      if (latch && alm_reg && !alarm_reset_i)
         alm_next = 1'b1;
   end
   always_ff @(posedge core_clk_i)
   begin
      armed_reg   <= rst_i ? 1'b0 : armed_next;
      was_out_reg <= rst_i ? 1'b0 : was_out_next;
      alm_reg     <= rst_i ? 1'b0 : alm_next;
   end

   // ==========================================
   // Registered outputs
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         measured_process_value_o     <= '0;
         derivative_term_o            <= 32'h0;
         freq_ref_o                   <= pssc_pkg::RESET_VALUE;
         accel_time_o                 <= pssc_pkg::RESET_VALUE;
         use_pid_o                    <= 1'b0;
         stop_o                       <= 1'b0;
         stabilize_active_indicator_o <= 1'b0;
         pid_alarm_output_o           <= 1'b0;
         feedback_alarm_output_o      <= 1'b0;
      end
      else
      begin
         measured_process_value_o     <= pv;
         derivative_term_o            <= dterm_reg;
         freq_ref_o                   <= (st_next == ST_STAB) ? sfreq
                                         : pssc_pkg::FREQ_ZERO;
         accel_time_o                 <= stab_cfg_i.stabilize_accel_time;
         use_pid_o                    <= (st_next == ST_PID);
         stop_o                       <= (st_next == ST_STOP);
         stabilize_active_indicator_o <= (st_next == ST_STAB);
         pid_alarm_output_o           <= alm_next
            && (do_function_i == pssc_pkg::FUNC_PID_ALARM_OUTPUT);
         feedback_alarm_output_o      <= alm_next
            && (do_function_i == pssc_pkg::FUNC_FB_ALM);
      end
   end

   AST_IND_MATCH: assert property (
      stabilize_active_indicator_o |-> freq_ref_o != 16'h0000)
      else $error("indicator without stabilize frequency");
   // The output was set from the limit one edge earlier
   AST_LOWLIM: assert property (
      stabilize_active_indicator_o
      |-> freq_ref_o >= $past(stab_cfg_i.low_frequency_limit))
      else $error("stabilize frequency below low limit");
   AST_DZERO: assert property (
      (derivative_time_setting_i == 16'h0000) [*3]
      |-> derivative_term_o == 32'h0)
      else $error("derivative term with zero time");
   AST_PIDONLY: assert property (
      !pid_mode_i |=> !stabilize_active_indicator_o)
      else $error("stabilize outside pid mode");
   AST_CANCEL: assert property (
      (st_reg == ST_STAB && cancel
      && pv < W'(stab_cfg_i.stabilize_level) && run_cmd_i && pid_mode_i)
      |=> stop_o)
      else $error("cancel did not stop");
   AST_LEVEL: assert property (
      (st_reg == ST_STAB && pv >= W'(stab_cfg_i.stabilize_level)
       && run_cmd_i && pid_mode_i) |=> use_pid_o)
      else $error("level reached without pid handover");
   AST_ENTRY: assert property (
      (st_reg == ST_IDLE && !motor_stopped_i)
      |=> !stabilize_active_indicator_o)
      else $error("stabilize entered while running");
   AST_ZEROF: assert property (
      (st_reg == ST_IDLE && stab_cfg_i.stabilize_frequency == 16'h0000)
      |=> !stabilize_active_indicator_o)
      else $error("stabilize with zero frequency");
   AST_LATCH: assert property (
      (alm_reg && latch && !alarm_reset_i) |=> alm_reg)
      else $error("latched alarm released");
endmodule : pssc_ctrl

// >>> core/pssc_lpf.sv
// First-order low-pass feedback filter stage
`timescale 1ns/1ps
module pssc_lpf #(
   parameter int unsigned W = 16
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic         tick_i,
   input  wire logic [15:0]  tau_i,
   input  wire logic [W-1:0] x_i,
   output logic      [W-1:0] y_o
);
   logic [W+15:0] acc_reg;
   logic [W+15:0] acc_next;
   logic [W+15:0] step;
   logic [W-1:0]  y_now;
   logic [31:0]   div;

   assign y_now = acc_reg[W+15:16];
   assign y_o   = y_now;

   always_comb
   begin
      div      = ({16'h0000, tau_i} * 32'(pssc_pkg::TENTH_TICKS)) + 32'h1;
      step     = ({x_i, 16'h0000} - acc_reg);
      acc_next = acc_reg;
      if (tick_i)
      begin
         if (tau_i == 16'h0000)
            acc_next = {x_i, 16'h0000};
         else if (x_i >= y_now)
            acc_next = acc_reg + (W+16)'(step / div);
         else
            acc_next = acc_reg - (W+16)'(({acc_reg} - {x_i, 16'h0000})
                       / div);
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         acc_reg <= '0;
      else
         acc_reg <= acc_next;
   end
endmodule : pssc_lpf

// >>> core/pssc_pkg.sv
// Package: shared types and constants for the PID start-stabilize block
package pssc_pkg;
   // ==========================================
   // Widths and settings ranges
   localparam int unsigned DATA_W          = 16;
   localparam logic [15:0] DERIV_MAX       = 16'hea60; // 600.00 s in 0.01 s
   localparam logic [15:0] FILT_MAX        = 16'h2328; // 900.0 s in 0.1 s
   localparam logic [15:0] FREQ_ZERO       = 16'h0000;
   localparam logic [15:0] RESET_VALUE     = 16'h0000;
   // ==========================================
   // Control cycle timing
   localparam int unsigned CLK_HZ          = 40000000;
   localparam int unsigned CTRL_PERIOD_US  = 1000;
   localparam int unsigned CTRL_CYCLES     = CLK_HZ / 1000000 * CTRL_PERIOD_US;
   // Time settings count control cycles of 1 ms; 0.1 s is 100 of them
   localparam int unsigned TENTH_TICKS     = 100;
   // ==========================================
   // Alarm types
   localparam logic [3:0]  ALM_ABS         = 4'h1;
   localparam logic [3:0]  ALM_DEV_FIRST   = 4'h5;
   localparam logic [3:0]  ALM_LAST        = 4'h8;
   // Digital terminal function codes
   localparam logic [7:0]  FUNC_CANCEL     = 8'h48; // 72
   localparam logic [7:0]  FUNC_PID_ALARM_OUTPUT    = 8'h2a; // 42
   localparam logic [7:0]  FUNC_FB_ALM     = 8'h32; // 50

   typedef struct packed {
      logic [15:0] stabilize_frequency;
      logic [15:0] stabilize_level;
      logic [15:0] stabilize_max_time;
      logic [15:0] stabilize_accel_time;
      logic [15:0] low_frequency_limit;
   } pssc_stab_cfg_t;

   typedef struct packed {
      logic [3:0]  alarm_type_select;
      logic [15:0] upper_alarm_limit;
      logic [15:0] lower_alarm_limit;
   } pssc_alarm_cfg_t;
endpackage : pssc_pkg

// >>> testbench/pssc_sensor_model.sv
// Feedback sensor and digital terminal model for the stabilize block
`timescale 1ns/1ps
module pssc_sensor_model (
   input  wire logic        core_clk_i,
   input  wire logic [15:0] pv_set_i,
   input  wire logic        cancel_req_i,
   input  wire logic        cancel_assign_i,
   input  wire logic        alarm_sel_i,
   output logic      [15:0] feedback_o,
   output logic             stabilize_cancel_input_o,
   output logic      [7:0]  di_function_o,
   output logic      [7:0]  do_function_o
);
   // ==========================================
   // Sensor and terminals
   initial
   begin
      feedback_o               = 16'h0000;
      stabilize_cancel_input_o = 1'b0;
   end
   // Sample-and-hold converter: a new reading lands just after an edge
   always @(posedge core_clk_i) feedback_o <= pv_set_i;
   // A contact is not clock aligned, so the pin moves off the edge
   always @(cancel_req_i) stabilize_cancel_input_o <= #7 cancel_req_i;
   assign di_function_o = cancel_assign_i ? pssc_pkg::FUNC_CANCEL
                                          : 8'h00;
   assign do_function_o = alarm_sel_i ? pssc_pkg::FUNC_FB_ALM
                                      : pssc_pkg::FUNC_PID_ALARM_OUTPUT;
endmodule : pssc_sensor_model

// >>> testbench/test_pid_start_stabilize_ctrl.sv
// Self-checking bench for the start-stabilize and alarm block
`timescale 1ns/1ps
module test_pid_start_stabilize_ctrl;
   // ==========================================
   // Signals
   typedef struct packed {
      logic [6:0]  fl; // pid, stopped, cancel, assign, chk_pid, act, pid
      logic [15:0] frq;
      logic [15:0] low;
      logic [15:0] fref;
   } pssc_row_t;
   logic                      core_clk_i      = 1'b0;
   logic                      rst_i           = 1'b1;
   logic                      run_cmd_i       = 1'b0;
   logic                      pid_mode_i      = 1'b1;
   logic                      motor_stopped_i = 1'b1;
   logic                      alarm_reset_i   = 1'b0;
   logic [15:0]               pv_set          = 16'h0300;
   logic                      cancel_req      = 1'b0;
   logic                      cancel_assign   = 1'b1;
   logic                      alarm_sel       = 1'b0;
   logic [15:0]               dtime           = 16'h0000;
   pssc_pkg::pssc_stab_cfg_t  stab_cfg;
   pssc_pkg::pssc_alarm_cfg_t alarm_cfg;
   logic [15:0]               feedback;
   logic [15:0]               mpv;
   logic [31:0]               deriv;
   logic [15:0]               fref;
   logic [15:0]               accel;
   logic                      use_pid;
   logic                      stop;
   logic                      active;
   logic                      pid_alarm_output;
   logic                      fb_alm;
   logic                      cancel_pin;
   logic [7:0]                di_fn;
   logic [7:0]                do_fn;
   pssc_row_t                 rows [9];
   int                        bad_count = 0;
   int                        n_checks  = 0;

   always #12.5 core_clk_i = ~core_clk_i;

   // ==========================================
   // Instances
   pssc_sensor_model sensor (
      .core_clk_i(core_clk_i), .pv_set_i(pv_set), .cancel_req_i(cancel_req),
      .cancel_assign_i(cancel_assign), .alarm_sel_i(alarm_sel),
      .feedback_o(feedback), .stabilize_cancel_input_o(cancel_pin),
      .di_function_o(di_fn), .do_function_o(do_fn));
   pssc_ctrl uut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .run_cmd_i(run_cmd_i),
      .pid_mode_i(pid_mode_i), .motor_stopped_i(motor_stopped_i),
      .stabilize_cancel_input_i(cancel_pin), .alarm_reset_i(alarm_reset_i),
      .di_function_i(di_fn), .do_function_i(do_fn),
      .derivative_time_setting_i(dtime), .feedback_filter_time_i(16'h0000),
      .stab_cfg_i(stab_cfg), .alarm_cfg_i(alarm_cfg),
      .process_setpoint_i(16'h0180), .feedback_i(feedback),
      .measured_process_value_o(mpv), .derivative_term_o(deriv),
      .freq_ref_o(fref), .accel_time_o(accel), .use_pid_o(use_pid),
      .stop_o(stop), .stabilize_active_indicator_o(active),
      .pid_alarm_output_o(pid_alarm_output), .feedback_alarm_output_o(fb_alm));

   // ==========================================
   // Tasks
   task automatic cycles(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask : cycles

   task automatic test_done;
      $display("Checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // Waits on use_pid when pick is set, otherwise on stop
   task automatic wait_on(input string nm, input int lim, input bit pick);
      for (int k = 0; k < lim && (pick ? use_pid : stop) !== 1'b1; k++)
         @(negedge core_clk_i);
      check(nm, {31'h0, pick ? use_pid : stop}, 32'h1);
      if ((pick ? use_pid : stop) !== 1'b1)
         test_done();
   endtask : wait_on

   // Ticks come every 40000 clocks, so this bound spans one of them
   task automatic wait_pv(input logic [15:0] v);
      for (int k = 0; k < 45000 && mpv !== v; k++)
         @(negedge core_clk_i);
      check("filtered value", {16'h0, mpv}, {16'h0, v});
      if (mpv !== v)
         test_done();
      cycles(3);
   endtask : wait_pv

   task automatic setup(input pssc_row_t r);
      {pid_mode_i, motor_stopped_i, cancel_req, cancel_assign} = r.fl[6:3];
      stab_cfg.stabilize_frequency = r.frq;
      stab_cfg.low_frequency_limit = r.low;
      run_cmd_i = 1'b0;
      cycles(4);
      run_cmd_i = 1'b1;
   endtask : setup

   // ==========================================
   // Sequence
   initial
   begin
      #2300000;
      bad_count++;
      $display("MISMATCH watchdog expired");
      test_done();
   end

   initial
   begin
      stab_cfg  = '{16'h0200, 16'hffff, 16'h0064, 16'h0123, 16'h0100};
      alarm_cfg = '{4'h3, 16'h0200, 16'h0100};
      rows = '{'{7'h6e, 16'h0200, 16'h0100, 16'h0200},
               '{7'h6e, 16'h0080, 16'h0100, 16'h0100},
               '{7'h6e, 16'h0100, 16'h0100, 16'h0100},
               '{7'h6d, 16'h0000, 16'h0100, 16'h0000},
               '{7'h6e, 16'h0001, 16'h0000, 16'h0001},
               '{7'h4d, 16'h0200, 16'h0100, 16'h0000},
               '{7'h7d, 16'h0200, 16'h0100, 16'h0000},
               '{7'h76, 16'h0200, 16'h0100, 16'h0200},
               '{7'h28, 16'h0200, 16'h0100, 16'h0000}};
      cycles(8);
      check("reset outputs", {active, use_pid, stop, pid_alarm_output, fb_alm, fref},
            32'h0);
      rst_i = 1'b0;
      foreach (rows[i])
      begin
         setup(rows[i]);
         cycles(3);
         check("active", active, rows[i].fl[1]);
         check("freq_ref", fref, rows[i].fref);
         if (rows[i].fl[2])
            check("use_pid", use_pid, rows[i].fl[0]);
         if (rows[i].fl[1])
            check("accel", accel, 16'h0123);
      end
      // Cancel in mid-stabilize must give stop, and stop must clear once run drops
      setup(rows[0]);
      cycles(3);
      cancel_req = 1'b1;
      wait_on("stop", 8, 1'b0);
      check("active", active, 1'b0);
      cancel_req = 1'b0;
      run_cmd_i  = 1'b0;
      cycles(4);
      check("stop", stop, 1'b0);
      // Zero stabilize time expires on the first stabilize cycle
      stab_cfg.stabilize_max_time = 16'h0000;
      setup(rows[0]);
      wait_on("stop", 4, 1'b0);
      run_cmd_i = 1'b0;
      stab_cfg.stabilize_max_time = 16'h0064;
      wait_pv(16'h0300);
      check("derivative", deriv, 32'h0);
      check("pid alarm", pid_alarm_output, 1'b1);
      check("fb alarm", fb_alm, 1'b0);
      // Level already met at start: hand over to the loop after one stabilize cycle
      stab_cfg.stabilize_level = 16'h0200;
      setup(rows[0]);
      wait_on("use_pid", 6, 1'b1);
      cycles(1);
      check("active", active, 1'b0);
      run_cmd_i = 1'b0;
      pv_set    = 16'h0180;
      dtime     = 16'hffff;
      wait_pv(16'h0180);
      // Clamped 600.00 s times a deviation step of -0x300
      check("derivative", deriv, 32'hfd40e000);
      check("pid alarm", pid_alarm_output, 1'b1);
      alarm_sel = 1'b1;
      dtime     = 16'h0000;
      cycles(3);
      check("derivative", deriv, 32'h0);
      check("fb alarm", fb_alm, 1'b1);
      check("pid alarm", pid_alarm_output, 1'b0);
      alarm_reset_i = 1'b1;
      cycles(2);
      alarm_reset_i = 1'b0;
      cycles(3);
      check("fb alarm", fb_alm, 1'b0);
      // Mid-run reset: a deviation hold alarm waits for out, then in
      rst_i     = 1'b1;
      alarm_cfg = '{4'h6, 16'h0000, 16'h0100};
      cycles(2);
      rst_i = 1'b0;
      cycles(3);
      check("fb alarm", fb_alm, 1'b0);
      alarm_cfg.lower_alarm_limit = 16'h0180;
      cycles(2);
      alarm_cfg.lower_alarm_limit = 16'h0100;
      cycles(2);
      check("fb alarm", fb_alm, 1'b1);
      test_done();
   end
endmodule : test_pid_start_stabilize_ctrl
